/* File: logic/urb_params.svh */
// urb_params.svh: offsets, field positions, reset values, timing counts
// assumes: included by the top module of the uart block and by the testbench
//
// Behaviour
// RULE1: break is start, twelve zeros, stop
// RULE2: break starts on tx write with break set
// RULE3: hardware clears break request after stop bit
// RULE4: software waits for shift empty first
// RULE5: break overrides all other transmitter activity
// RULE6: software never clears break request early
// RULE7: break raises no transmit interrupt
// RULE8: shift empty flag works during break
// RULE9: lin header is dummy write then sync
// RULE10: 16x mode majority of samples 7-9
// RULE11: 4x mode samples once at midpoint
// RULE12: recovery at 16x, shifter per bit
// RULE13: stop bit moves word into fifo
// RULE14: fifth word sets overrun, blocks fifo
// RULE15: clearing overrun empties receive fifo
// RULE16: low stop bit sets framing error
// RULE17: parity error for head word, not 9-bit
// RULE18: error flags stored with each word
// RULE19: errors raise error interrupt when enabled
// RULE20: receive interrupt per rx irq select
// RULE21: receiver idle bit is read only
// RULE22: data available while fifo not empty
// RULE23: parity select 11 means nine bits
// RULE24: clearing tx enable aborts transmitter
// RULE25: buffer read pops the head word
// RULE26: reset empties fifo, clears flags, break
`ifndef URB_PARAMS_SVH
`define URB_PARAMS_SVH

`define URB_OFS_MODE    12'h000
`define URB_OFS_STATUS  12'h004
`define URB_OFS_TXBUF   12'h008
`define URB_OFS_RXBUF   12'h00c
`define URB_OFS_BAUD    12'h010
`define URB_OFS_TXIRQ   12'h014

// mode register fields
`define URB_MODE_DATA_PARITY_SELECT_LO  1
`define URB_MODE_HSPEED    3
`define URB_MODE_ERRIE     4
// status/control register fields
`define URB_ST_RXDA        0
`define URB_ST_OVERRUN_ERROR        1
`define URB_ST_FRAMING_ERROR        2
`define URB_ST_PARITY_ERROR        3
`define URB_ST_RECEIVER_IDLE       4
`define URB_ST_RXISEL_LO   6
`define URB_ST_SHIFT_EMPTY_FLAG        8
`define URB_ST_TXBF        9
`define URB_ST_TXEN        10
`define URB_ST_BREAK_REQUEST_ALIAS       11

`define URB_BAUD_RST       16'h0000
`define URB_FIFO_DEPTH     3'h4
`define URB_BRK_ZEROS      4'hc
`define URB_OVS_16X        4'hf
`define URB_OVS_4X         4'h3
`define URB_MAJ_FIRST      4'h6
`define URB_MID_4X         4'h1

`endif

/* File: logic/urb_pkg.sv */
// urb_pkg.sv: types shared by the uart receive / break transmit block
// assumes: urb_params.svh in the include path
package urb_pkg;
  typedef enum logic [1:0] {
    URB_RX_IDLE  = 2'b00,
    URB_RX_START = 2'b01,
    URB_RX_DATA  = 2'b10,
    URB_RX_STOP  = 2'b11
  } urb_rx_e;

  typedef enum logic [1:0] {
    URB_TX_IDLE  = 2'b00,
    URB_TX_START = 2'b01,
    URB_TX_DATA  = 2'b10,
    URB_TX_STOP  = 2'b11
  } urb_tx_e;

  // one fifo entry: data plus its own error flags
  typedef struct packed {
    logic       parity_error;
    logic       framing_error;
    logic [8:0] data;
  } urb_entry_s;
endpackage

/* File: logic/urb_uart.sv */
// urb_uart.sv: uart receiver with break-capable transmitter, apb slave
// assumes: one clock, synchronous active-low reset, apb master on CLK
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "urb_params.svh"

module urb_uart
(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_IN,
  output logic             TX_OUT,
  output logic             TX_OE,
  output logic             RX_IRQ,
  output logic             ERR_IRQ,
  output logic             TX_IRQ
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic par_of(input logic [7:0] d, input logic [1:0] sel);
    begin
      par_of = (^d) ^ (sel == 2'b10);
    end
  endfunction

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic        wr;
  logic        rd;
  logic [1:0]  data_parity_select;
  logic        high_speed_select;
  logic        error_irq_enable;
  logic [1:0]  rx_irq_select;
  logic        transmit_enable;
  logic        break_request;
  logic        overrun_error;
  logic [15:0] baud;
  logic [15:0] baud_cnt;
  logic        tick;
  logic        mode_wr;
  logic        stat_wr;

  assign wr      = PSEL && PENABLE && PWRITE;
  assign rd      = PSEL && PENABLE && !PWRITE;
  assign PREADY  = 1'b1;
  assign mode_wr = wr && PADDR == `URB_OFS_MODE;
  assign stat_wr = wr && PADDR == `URB_OFS_STATUS;
  assign PSLVERR = PSEL && PENABLE && !(PADDR == `URB_OFS_MODE
                   || PADDR == `URB_OFS_STATUS || PADDR == `URB_OFS_TXBUF
                   || PADDR == `URB_OFS_RXBUF || PADDR == `URB_OFS_BAUD
                   || PADDR == `URB_OFS_TXIRQ);

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      data_parity_select <= 2'b00;
      high_speed_select  <= 1'b0;
      error_irq_enable   <= 1'b0;
      baud               <= `URB_BAUD_RST;
    end
    else if (mode_wr)
    begin
      data_parity_select <= PWDATA[`URB_MODE_DATA_PARITY_SELECT_LO +: 2];
      high_speed_select  <= PWDATA[`URB_MODE_HSPEED];
      error_irq_enable   <= PWDATA[`URB_MODE_ERRIE];
    end
    else if (wr && PADDR == `URB_OFS_BAUD)
      baud <= PWDATA[15:0];
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
      rx_irq_select <= 2'b00;
    else if (stat_wr)
      rx_irq_select <= PWDATA[`URB_ST_RXISEL_LO +: 2];
  end

  // sample clock: one tick every baud+1 cycles (16x or 4x bit rate)
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      baud_cnt <= 16'h0000;
    else if (baud_cnt >= baud)
      baud_cnt <= 16'h0000;
    else
      baud_cnt <= baud_cnt + 16'h0001;
  end
  assign tick = (baud_cnt >= baud);

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  urb_pkg::urb_rx_e   rx_st;
  logic [3:0]         os_cnt;
  logic [3:0]         os_last;
  logic [3:0]         bit_cnt;
  logic [3:0]         nbits;
  logic [1:0]         votes;
  logic [9:0]         receive_shift_reg;
  logic               bit_val;
  logic               bit_end;
  logic               word_done;
  logic               held;
  logic               do_push;
  logic               do_pop;
  logic               clr_overrun_error;
  logic               rx_parity_on;
  urb_pkg::urb_entry_s fifo [0:3];
  urb_pkg::urb_entry_s new_ent;
  logic [1:0]         wp;
  logic [1:0]         rp;
  logic [2:0]         cnt;
  logic [2:0]         next_cnt;

  // see RULE11 see RULE12
  assign os_last = high_speed_select ? `URB_OVS_4X : `URB_OVS_16X;
  assign bit_end = tick && os_cnt == os_last;
  // see RULE10
  assign bit_val = high_speed_select ? RX_IN
                   : (votes[1] || (votes[0] && RX_IN));
  assign rx_parity_on = data_parity_select == 2'b01
                     || data_parity_select == 2'b10;
  // see RULE23
  assign nbits = (data_parity_select == 2'b11 || rx_parity_on)
                 ? 4'h9 : 4'h8;

  // majority votes: count of highs at 7th and 8th edges
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      votes <= 2'b00;
    else if (tick && os_cnt == `URB_MAJ_FIRST)
      votes <= {1'b0, RX_IN};
    else if (tick && os_cnt == `URB_MAJ_FIRST + 4'h1)
      votes <= {votes[0] & RX_IN, votes[0] ^ RX_IN};
  end

  logic samp;
  assign samp = tick && (high_speed_select ? os_cnt == `URB_MID_4X
                         : os_cnt == `URB_MAJ_FIRST + 4'h2);

  always_ff @(posedge CLK)
  begin
    if (!NRST || rx_st == urb_pkg::URB_RX_IDLE)
      os_cnt <= 4'h0;
    else if (bit_end)
      os_cnt <= 4'h0;
    else if (tick)
      os_cnt <= os_cnt + 4'h1;
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      rx_st             <= urb_pkg::URB_RX_IDLE;
      bit_cnt           <= 4'h0;
      receive_shift_reg <= 10'h000;
    end
    else
    begin
      case (rx_st)
        urb_pkg::URB_RX_IDLE:
          if (!RX_IN && !held)
            rx_st <= urb_pkg::URB_RX_START;
        urb_pkg::URB_RX_START:
          if (samp && bit_val)
            rx_st <= urb_pkg::URB_RX_IDLE;
          else if (bit_end)
          begin
            rx_st   <= urb_pkg::URB_RX_DATA;
            bit_cnt <= 4'h0;
          end
        urb_pkg::URB_RX_DATA:
        begin
          if (samp)
            receive_shift_reg <= {bit_val, receive_shift_reg[9:1]};
          if (bit_end)
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == nbits - 4'h1)
              rx_st <= urb_pkg::URB_RX_STOP;
          end
        end
        urb_pkg::URB_RX_STOP:
          if (samp)
          begin
            // see RULE16
            receive_shift_reg <= {bit_val, receive_shift_reg[9:1]};
            rx_st <= urb_pkg::URB_RX_IDLE;
          end
        default:
          rx_st <= urb_pkg::URB_RX_IDLE;
      endcase
    end
  end

  assign word_done = rx_st == urb_pkg::URB_RX_STOP && samp;

  // word waiting in shifter after overrun; held until flag cleared
  always_ff @(posedge CLK)
  begin
    if (!NRST || clr_overrun_error)
      held <= 1'b0;
    else if (word_done && cnt == `URB_FIFO_DEPTH)
      held <= 1'b1;
  end

  // assemble entry from shifted bits (lsb first, last data or parity bit at top)
  logic [8:0] rx_word;
  always_comb
  begin
    rx_word = 9'h000;
    new_ent = '0;
    if (nbits == 4'h9)
      rx_word = receive_shift_reg[9:1];
    else
      rx_word = {1'b0, receive_shift_reg[9:2]};
    new_ent.data = (data_parity_select == 2'b11) ? rx_word
                   : {1'b0, rx_word[7:0]};
    new_ent.framing_error = !bit_val;
    // see RULE17
    new_ent.parity_error = rx_parity_on
                   && (par_of(rx_word[7:0], data_parity_select) != rx_word[8]);
  end

  // see RULE14
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      overrun_error <= 1'b0;
    else if (word_done && cnt == `URB_FIFO_DEPTH)
      overrun_error <= 1'b1;
    else if (clr_overrun_error)
      overrun_error <= 1'b0;
  end

  assign clr_overrun_error = stat_wr && overrun_error && !PWDATA[`URB_ST_OVERRUN_ERROR];
  // see RULE13 see RULE14
  assign do_push  = word_done && cnt != `URB_FIFO_DEPTH && !overrun_error;
  // see RULE25
  assign do_pop   = rd && PADDR == `URB_OFS_RXBUF && cnt != 3'h0;

  always_comb
  begin
    next_cnt = cnt;
    if (do_push && !do_pop)
      next_cnt = cnt + 3'h1;
    else if (do_pop && !do_push)
      next_cnt = cnt - 3'h1;
  end

  // see RULE15 see RULE26
  always_ff @(posedge CLK)
  begin
    if (!NRST || clr_overrun_error)
    begin
      wp  <= 2'b00;
      rp  <= 2'b00;
      cnt <= 3'h0;
    end
    else
    begin
      cnt <= next_cnt;
      if (do_push)
        wp <= wp + 2'b01;
      if (do_pop)
        rp <= rp + 2'b01;
    end
  end

  // see RULE18
  always_ff @(posedge CLK)
  begin
    if (do_push)
      fifo[wp] <= new_ent;
  end

  urb_pkg::urb_entry_s head;
  assign head = (cnt != 3'h0) ? fifo[rp] : '0;

  // see RULE20
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      RX_IRQ <= 1'b0;
    else
      RX_IRQ <= do_push && (!rx_irq_select[1]
                || (!rx_irq_select[0] && next_cnt >= 3'h3)
                || next_cnt == `URB_FIFO_DEPTH);
  end

  // see RULE19
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      ERR_IRQ <= 1'b0;
    else
      ERR_IRQ <= error_irq_enable && ((word_done && cnt == `URB_FIFO_DEPTH
                 && !overrun_error) || (do_push && (new_ent.framing_error
                 || new_ent.parity_error)));
  end

  // ----------------------------------------------------------------
  // break transmitter
  // ----------------------------------------------------------------
  urb_pkg::urb_tx_e tx_st;
  logic [3:0]       tx_os;
  logic [3:0]       tx_bits;
  logic             tx_bit_end;
  logic             brk_go;

  assign tx_bit_end = tick && tx_os == os_last;
  // see RULE2
  assign brk_go = wr && PADDR == `URB_OFS_TXBUF && break_request
                  && transmit_enable && tx_st == urb_pkg::URB_TX_IDLE;

  always_ff @(posedge CLK)
  begin
    if (!NRST)
      transmit_enable <= 1'b0;
    else if (stat_wr)
      transmit_enable <= PWDATA[`URB_ST_TXEN];
  end

  // see RULE3 see RULE26
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      break_request <= 1'b0;
    else if (tx_st == urb_pkg::URB_TX_STOP && tx_bit_end)
      break_request <= 1'b0;
    else if (stat_wr)
      break_request <= PWDATA[`URB_ST_BREAK_REQUEST_ALIAS];
  end

  // see RULE1 see RULE5 see RULE24
  always_ff @(posedge CLK)
  begin
    if (!NRST || !transmit_enable)
    begin
      tx_st   <= urb_pkg::URB_TX_IDLE;
      tx_os   <= 4'h0;
      tx_bits <= 4'h0;
    end
    else
    begin
      tx_os <= tx_bit_end ? 4'h0 : (tick && tx_st != urb_pkg::URB_TX_IDLE)
               ? tx_os + 4'h1 : tx_os;
      case (tx_st)
        urb_pkg::URB_TX_IDLE:
          if (brk_go)
          begin
            tx_st <= urb_pkg::URB_TX_START;
            tx_os <= 4'h0;
          end
        urb_pkg::URB_TX_START:
          if (tx_bit_end)
          begin
            tx_st   <= urb_pkg::URB_TX_DATA;
            tx_bits <= 4'h0;
          end
        urb_pkg::URB_TX_DATA:
          if (tx_bit_end)
          begin
            tx_bits <= tx_bits + 4'h1;
            if (tx_bits == `URB_BRK_ZEROS - 4'h1)
              tx_st <= urb_pkg::URB_TX_STOP;
          end
        urb_pkg::URB_TX_STOP:
          if (tx_bit_end)
            tx_st <= urb_pkg::URB_TX_IDLE;
        default:
          tx_st <= urb_pkg::URB_TX_IDLE;
      endcase
    end
  end

  assign TX_OE  = transmit_enable;
  // released pin idles high at once, before the state clears
  assign TX_OUT = !transmit_enable
                  || tx_st == urb_pkg::URB_TX_IDLE
                  || tx_st == urb_pkg::URB_TX_STOP;
  // see RULE7
  assign TX_IRQ = 1'b0;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      PRDATA <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE)
    begin
      PRDATA <= 32'h0000_0000;
      case (PADDR)
        `URB_OFS_MODE:
          PRDATA <= {27'h0, error_irq_enable, high_speed_select,
                     data_parity_select, 1'b0};
        `URB_OFS_STATUS:
          // see RULE8 see RULE21 see RULE22
          PRDATA <= {20'h0, break_request, transmit_enable, 1'b0,
                     tx_st == urb_pkg::URB_TX_IDLE, rx_irq_select, 1'b0,
                     rx_st == urb_pkg::URB_RX_IDLE && !held, head.parity_error,
                     head.framing_error, overrun_error, cnt != 3'h0};
        `URB_OFS_RXBUF:
          PRDATA <= {23'h0, head.data};
        `URB_OFS_BAUD:
          PRDATA <= {16'h0, baud};
        default:
          PRDATA <= 32'h0000_0000;
      endcase
    end
  end

endmodule

/* File: test/testbench.sv */
// testbench.sv: register-level tests of the uart block over apb
// assumes: urb_params.svh in the include path, divisor left at 0
`timescale 1ns/100ps
`include "urb_params.svh"
module testbench;
  logic        clk, nrst, psel, penable, pwrite, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rx_in, tx_out, tx_oe, rx_irq, err_irq;
  logic        tx_line;
  int          num_errors, tests_run, rxc, errc, c0, e0, i;
  localparam logic [31:0] IDLE = 32'h110;
  localparam logic [11:0] ST = `URB_OFS_STATUS;
  localparam logic [11:0] RB = `URB_OFS_RXBUF;
  localparam logic [11:0] MD = `URB_OFS_MODE;

  urb_uart urb_uart_i (.CLK(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RX_IN(rx_in),
    .TX_OUT(tx_out), .TX_OE(tx_oe), .RX_IRQ(rx_irq), .ERR_IRQ(err_irq),
    .TX_IRQ());
  assign tx_line = tx_oe ? tx_out : 1'b1;
  urb_node urb_node_i (.CLK(clk), .RX_LINE(rx_in), .TX_LINE(tx_line));

  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    if (rx_irq === 1'b1)
      rxc++;
    if (err_irq === 1'b1)
      errc++;
  end

  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  task chk(input string n, input logic [31:0] seen, input logic [31:0] e);
    tests_run++;
    if (seen !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, seen);
    end
  endtask

  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] e, input string n,
           input logic [31:0] m = 32'hffffffff);
    apb(a, 1'b0, 32'h0);
    chk(n, rd & m, e);
  endtask

  task rx(input logic [8:0] d, input int n, input logic stp, input int bt);
    urb_node_i.send(d, n, stp, bt);
    repeat (4) @(posedge clk);
  endtask

  task end_sim;
    if (num_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------
  initial
  begin
    clk = 0; nrst = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; rxc = 0; errc = 0;
    num_errors = 0; tests_run = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rdc(ST, IDLE, "status_reset");
    rdc(12'h020, 32'h0, "unmapped");
    chk("slverr", {31'h0, slv}, 32'h1);
    c0 = rxc;
    rx(9'h0a5, 8, 1'b1, 16);
    rdc(ST, IDLE | 32'h1, "avail");
    chk("rxirq_00", rxc - c0, 1);
    rdc(RB, 32'h0a5, "rx16");
    rdc(ST, IDLE, "empty");
    apb(MD, 1'b1, 32'h008);
    rx(9'h05a, 8, 1'b1, 4);
    rdc(RB, 32'h05a, "rx4");
    apb(MD, 1'b1, 32'h012);
    e0 = errc;
    rx(9'h103, 9, 1'b1, 16);
    rx(9'h003, 9, 1'b1, 16);
    rdc(ST, IDLE | 32'h9, "parity_error_head");
    chk("parity_error_irq", errc - e0, 1);
    rdc(RB, 32'h03, "parity_error_data", 32'hff);
    rdc(ST, IDLE | 32'h1, "parity_error_next");
    rdc(RB, 32'h03, "good_data", 32'hff);
    apb(MD, 1'b1, 32'h006);
    apb(ST, 1'b1, 32'h040);
    c0 = rxc;
    rx(9'h1c3, 9, 1'b1, 16);
    chk("rxirq_01", rxc - c0, 1);
    rdc(RB, 32'h1c3, "nine_bit");
    apb(MD, 1'b1, 32'h010);
    apb(ST, 1'b1, 32'h080);
    c0 = rxc;
    e0 = errc;
    for (i = 1; i < 6; i++)
      rx(9'(i), 8, 1'b1, 16);
    rdc(ST, 32'h3, "overrun", 32'hf);
    chk("rxirq_10", rxc - c0, 2);
    chk("ovr_irq", errc - e0, 1);
    apb(ST, 1'b1, 32'h000);
    rdc(ST, 32'h0, "flushed", 32'hf);
    apb(ST, 1'b1, 32'h400);
    rdc(ST, 32'h500, "tx_idle", 32'hd00);
    apb(ST, 1'b1, 32'hc00);
    apb(`URB_OFS_TXBUF, 1'b1, 32'hff);
    apb(`URB_OFS_TXBUF, 1'b1, 32'h55);
    rdc(ST, 32'hc00, "brk_busy", 32'hd00);
    repeat (240) @(posedge clk);
    rdc(ST, 32'h500, "brk_done", 32'hd00);
    chk("brk_low", urb_node_i.last_low, 208);
    apb(ST, 1'b1, 32'h000);
    @(posedge clk);
    chk("tx_release", {31'h0, tx_oe}, 32'h0);
    e0 = errc;
    rx(9'h055, 8, 1'b0, 16);
    rdc(ST, 32'h5, "framing_error", 32'hf);
    chk("framing_error_irq", errc - e0, 1);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdc(ST, IDLE, "rerun_reset");
    end_sim;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim;
  end
endmodule

bind urb_uart urb_uart_chk #(.BRK_LOW(208)) urb_uart_chk_i (.CLK(CLK),
  .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .RX_IN(RX_IN), .TX_OUT(TX_OUT), .TX_OE(TX_OE),
  .RX_IRQ(RX_IRQ), .ERR_IRQ(ERR_IRQ), .TX_IRQ(TX_IRQ));

/* File: test/urb_node.sv */
// urb_node.sv: remote serial node sending frames, timing break lows
// assumes: driven from the bench top by hierarchical task calls
`timescale 1ns/100ps
module urb_node
(
  input  wire logic CLK,
  output logic      RX_LINE,
  input  wire logic TX_LINE
);
  int   run;
  int   last_low;

  initial
  begin
    RX_LINE = 1'b1;
    run = 0;
    last_low = 0;
  end

  // frame: start, n bits lsb first, stop level, bt clocks a bit
  task automatic send(input logic [8:0] d, input int n, input logic stp,
                      input int bt);
    int i;
    int k;
    for (i = 0; i < n + 2; i++)
      for (k = 0; k < bt; k++)
      begin
        @(posedge CLK);
        RX_LINE <= (i == 0) ? 1'b0 : (i == n + 1) ? stp : d[i - 1];
      end
    @(posedge CLK);
    RX_LINE <= 1'b1;
  endtask

  // length of the latest low run on the pulled-up output line
  always @(posedge CLK)
  begin
    if (TX_LINE !== 1'b1)
      run <= run + 1;
    else
    begin
      if (run != 0)
        last_low <= run;
      run <= 0;
    end
  end
endmodule

/* File: test/urb_uart_chk.sv */
// urb_uart_chk.sv: port-level assertions for the uart block
// assumes: bound to urb_uart; break timed at divisor 0 in 16x mode
`timescale 1ns/100ps
module urb_uart_chk
#(
  parameter int BRK_LOW = 208
)
(
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        RX_IN,
  input wire logic        TX_OUT,
  input wire logic        TX_OE,
  input wire logic        RX_IRQ,
  input wire logic        ERR_IRQ,
  input wire logic        TX_IRQ
);
  logic [8:0] low_run;
  logic       acc_bad;

  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  assign acc_bad = PSEL && PENABLE && (PADDR > 12'h014);

  // length of the current low run of the serial output
  always_ff @(posedge CLK)
  begin
    if (!NRST || TX_OUT)
      low_run <= 9'h000;
    else
      low_run <= low_run + 9'h001;
  end

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  AST_BRK_LEN: assert property (
    $rose(TX_OUT) && TX_OE |-> low_run == BRK_LOW)
    else $error("break low time wrong");
  AST_NO_TX_IRQ: assert property (!TX_IRQ)
    else $error("transmit interrupt raised");
  AST_RX_PULSE: assert property (RX_IRQ |=> !RX_IRQ)
    else $error("rx interrupt longer than one cycle");
  AST_ERR_PULSE: assert property (
    $rose(ERR_IRQ) |=> $fell(ERR_IRQ))
    else $error("error interrupt longer than one cycle");
  AST_RELEASE: assert property (!TX_OE |-> TX_OUT)
    else $error("released output not idle");
  AST_RESET: assert property (disable iff (1'b0)
    !NRST |=> !RX_IRQ && !ERR_IRQ && !TX_OE && TX_OUT)
    else $error("outputs not cleared by reset");
  AST_READY: assert property (PSEL |-> PREADY)
    else $error("pready low");
  AST_SLVERR: assert property (PSEL && PENABLE |-> PSLVERR == acc_bad)
    else $error("slave error mismatch");
  AST_BAD_RD: assert property (acc_bad && !PWRITE |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
endmodule
